/* File: rtl/opmode_defines.svh */
`ifndef OPMODE_DEFINES_SVH
`define OPMODE_DEFINES_SVH

// Register indices on the plain register port
`define SYSCTL_ADDR 4'h0
`define MODEMON_ADDR 4'h1
`define AREAWID_ADDR 4'h2
`define FLASHCTL_ADDR 4'h3
`define PORTSEL_ADDR 4'h4

// System control register fields and reset value
`define SYSCTL_RAM_ENABLE_BIT_BIT 0
`define SYSCTL_EXTERNAL_BUS_ENABLE_BIT_BIT 1
`define SYSCTL_RESET 8'hC1
`define SYSCTL_WMASK 8'hFB

// Flash control field
`define FLASHCTL_CMDEN_BIT 0

// Mode pin encodings
`define MODE_PINS_1 3'h1
`define MODE_PINS_2 3'h2
`define MODE_PINS_3 3'h3
`define MODE_PINS_4 3'h4
`define MODE_PINS_7 3'h7

// Port select register fields
`define PSEL_ADDR_LSB 0
`define PSEL_ADDR_MSB 2
`define PSEL_PORTD_BIT 3
`define PSEL_FCTL_LSB 4
`define PSEL_FCTL_MSB 7

`endif

/* File: rtl/opmode_pkg.sv */
package opmode_pkg;

    // Decoded operating mode, one-hot
    typedef enum logic [5:0] {
        MODE_NONE = 6'h01,
        MODE_1 = 6'h02,
        MODE_2 = 6'h04,
        MODE_3 = 6'h08,
        MODE_4 = 6'h10,
        MODE_7 = 6'h20
    } op_mode_t;

    // Memory region routing
    typedef enum logic [1:0] {
        REGION_RAM = 2'h0,
        REGION_EXTERNAL = 2'h1,
        REGION_RESERVED = 2'h2
    } region_map_t;

endpackage

/* File: rtl/mode_latch.sv */
`timescale 1ns/1ps
`include "opmode_defines.svh"

// Holds pin levels caught on a read of the mode monitor register
module mode_latch
    import opmode_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic capture_in,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] held_out
);

    logic [WIDTH-1:0] held_reg;

    // Cleared by reset, refreshed on each capture
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            held_reg <= '0;
        else if (capture_in)
            held_reg <= level_in;
    end

    assign held_out = held_reg;

endmodule

/* File: rtl/operating_mode_pin_select.sv */
`timescale 1ns/1ps
`include "opmode_defines.svh"

// Notes on behaviour
// - Bit 0 enables on-chip RAM, resets one
// - RAM enable restored when reset releases
// - Modes 1,2: ROM off, A-D bus, E when 16-bit
// - Mode 1 16-bit; 8-bit only if all
// - Modes 2,4 8-bit until any 16-bit area
// - Mode 3 acts as mode 7 plus boot, minus user program
// - Mode 4 ROM on, boots area 0
// - Mode 4 A-C inputs, switchable; D data
// - Modes 4,7 flash enable enters user program
// - Mode 7 single-chip, A-F I/O; G,H start I/O, switchable
// - Mode 7 external enable gives expanded mode
// - B,C fixed address modes 1,2; else switchable when expanded
// - D fixed data 1,2,4; E data when bus 16-bit
// - Port F control groups by mode
// - G0 control modes 1,2; rest switchable
// - RAM region external when enabled and RAM off
// - Expansion region external or reserved
// - Mode pins decode to five modes
// - Bit 1 enables external bus
// - Monitor reads live mode pins
module operating_mode_pin_select
    import opmode_pkg::*;
#(
    parameter int AREAS = 8,
    parameter bit FLASH_PRESENT = 1'b1
)
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] mode_select_pins_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    output logic rom_enable_out,
    output logic ram_enable_out,
    output logic ext_bus_active_out,
    output logic bus_16bit_out,
    output logic boot_mode_out,
    output logic user_program_mode_out,
    output logic [2:0] port_addr_out,
    output logic port_d_data_out,
    output logic port_e_data_out,
    output logic [7:0] port_f_ctrl_out,
    output logic [6:0] port_g_ctrl_out,
    output logic [7:0] port_h_ctrl_out,
    output logic [1:0] ram_region_map_out,
    output logic [1:0] exp_region_map_out
);

    logic [7:0] sysctl_reg;
    logic [7:0] sysctl_next;
    logic [AREAS-1:0] area_wide_reg;
    logic [AREAS-1:0] area_wide_next;
    logic flash_cmd_reg;
    logic [7:0] port_sel_reg;
    logic [6:0] port_g_sel_reg;
    logic [7:0] port_h_sel_reg;
    logic [7:0] reg_rdata_reg;
    logic [2:0] mode_held;
    op_mode_t mode_now;
    logic ram_en;
    logic ext_en;
    logic expanded;
    logic single_chip_class;
    logic [7:0] rdata_next;
    logic [7:0] port_f_next;

    // Pin pattern to one-hot mode; unused patterns give none
    function automatic op_mode_t decode_mode(input logic [2:0] pins);
        op_mode_t m;
        m = MODE_NONE;
        case (pins)
            `MODE_PINS_1: m = MODE_1;
            `MODE_PINS_2: m = MODE_2;
            `MODE_PINS_3: m = MODE_3;
            `MODE_PINS_4: m = MODE_4;
            `MODE_PINS_7: m = MODE_7;
            default: m = MODE_NONE;
        endcase
        return m;
    endfunction

    // Mode pins must stay put, so a live decode is safe
    assign mode_now = decode_mode(mode_select_pins_in);

    // Mode 3 behaves as mode 7 apart from boot and user program
    assign single_chip_class = (mode_now == MODE_3) || (mode_now == MODE_7);
    assign ram_en = sysctl_reg[`SYSCTL_RAM_ENABLE_BIT_BIT];
    assign ext_en = sysctl_reg[`SYSCTL_EXTERNAL_BUS_ENABLE_BIT_BIT];

    // Expanded modes always have the bus; 3 and 7 need the enable bit
    assign expanded = (mode_now == MODE_1) || (mode_now == MODE_2) || (mode_now == MODE_4)
        || (single_chip_class && ext_en);

    // Register writes; the reserved bit 2 stays zero
    assign sysctl_next = (sysctl_reg & ~`SYSCTL_WMASK) | (reg_wdata_in & `SYSCTL_WMASK);

    // Area widths seed from mode: mode 1 and mode 3 or 7 expansion start wide
    assign area_wide_next = reg_wdata_in[AREAS-1:0];

    // Reset loads the documented value, so release restores RAM enable
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sysctl_reg <= `SYSCTL_RESET;
        else if (reg_write_in && reg_addr_in == `SYSCTL_ADDR)
            sysctl_reg <= sysctl_next;
    end

    // Area width flag register; one bit per area, 1 means 16-bit
    logic area_init_done_reg;
    logic mode1_reg;
    logic ext_en_d_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            area_wide_reg <= '0;
            area_init_done_reg <= 1'b0;
            ext_en_d_reg <= 1'b0;
        end
        else
        begin
            area_init_done_reg <= 1'b1;
            ext_en_d_reg <= ext_en;
            if (reg_write_in && reg_addr_in == `AREAWID_ADDR)
                area_wide_reg <= area_wide_next;
            else if (!area_init_done_reg && mode_now == MODE_1)
                area_wide_reg <= '1;
            else if (single_chip_class && ext_en && !ext_en_d_reg)
                area_wide_reg <= '1;
        end
    end

    // Strap of mode 1 caught after release, not under reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mode1_reg <= 1'b0;
        else if (!area_init_done_reg)
            mode1_reg <= (mode_now == MODE_1);
    end

    // Flash command enable, only meaningful in modes 4 and 7
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flash_cmd_reg <= 1'b0;
        else if (reg_write_in && reg_addr_in == `FLASHCTL_ADDR)
            flash_cmd_reg <= reg_wdata_in[`FLASHCTL_CMDEN_BIT];
    end

    // Port function switches: A-C address, D data, F control bits
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            port_sel_reg <= 8'h00;
        else if (reg_write_in && reg_addr_in == `PORTSEL_ADDR)
            port_sel_reg <= reg_wdata_in;
    end

    // G and H control switches share one extra register pair
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_g_sel_reg <= 7'h00;
            port_h_sel_reg <= 8'hFF; // Held inverted, so port H starts as I/O
        end
        else if (reg_write_in && reg_addr_in == `PORTSEL_ADDR + 4'h1)
        begin
            port_g_sel_reg <= reg_wdata_in[6:0];
            port_h_sel_reg <= ~reg_wdata_in;
        end
    end

    // Monitor latch captures pins on every monitor read
    mode_latch #(
        .WIDTH(3)
    ) u_mode_latch (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .capture_in(reg_read_in && reg_addr_in == `MODEMON_ADDR),
        .level_in(mode_select_pins_in),
        .held_out(mode_held)
    );

    // Read data; the monitor shows live pins in the read cycle itself
    assign rdata_next = (reg_addr_in == `SYSCTL_ADDR) ? sysctl_reg :
        (reg_addr_in == `MODEMON_ADDR) ? {5'h00, mode_select_pins_in} :
        (reg_addr_in == `AREAWID_ADDR) ? 8'(area_wide_reg) :
        (reg_addr_in == `FLASHCTL_ADDR) ? {7'h00, flash_cmd_reg} :
        (reg_addr_in == `PORTSEL_ADDR) ? port_sel_reg :
        (reg_addr_in == `PORTSEL_ADDR + 4'h1) ? {1'b0, port_g_sel_reg} :
        8'h00;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_reg <= 8'h00;
        else if (reg_read_in)
            reg_rdata_reg <= rdata_next;
        else
            reg_rdata_reg <= 8'h00;
    end

    assign reg_rdata_out = reg_rdata_reg;

    // ROM off in modes 1 and 2 and for unused pin patterns; mode 4 boots from ROM in area 0
    assign rom_enable_out = (mode_now == MODE_4) || single_chip_class;
    assign ram_enable_out = ram_en;
    assign ext_bus_active_out = expanded;
    assign boot_mode_out = (mode_now == MODE_3);

    // Width tracks the area flags live, no reset needed
    assign bus_16bit_out = expanded && (|area_wide_reg);

    // User program mode in modes 4 and 7 of flash parts
    assign user_program_mode_out = FLASH_PRESENT && flash_cmd_reg
        && ((mode_now == MODE_4) || (mode_now == MODE_7));

    // Ports A-C: fixed address in 1,2; switchable in the other expanded modes
    assign port_addr_out = ((mode_now == MODE_1) || (mode_now == MODE_2)) ? 3'h7 :
        (expanded ? port_sel_reg[`PSEL_ADDR_MSB:`PSEL_ADDR_LSB] : 3'h0);

    // Port D fixed data in 1,2,4; else switchable in expansion
    assign port_d_data_out = (mode_now == MODE_1) || (mode_now == MODE_2) || (mode_now == MODE_4)
        || (expanded && port_sel_reg[`PSEL_PORTD_BIT]);

    // Port E is data exactly when the bus is 16 bits wide
    assign port_e_data_out = bus_16bit_out;

    // Port F in modes 1,2,4: 5,4 fixed control, 7,6,3 start control; expanded 3,7 all follow bit 7
    always_comb
    begin
        port_f_next = 8'h00;
        if (expanded && !single_chip_class)
        begin
            port_f_next[5:4] = 2'h3;
            port_f_next[7:6] = ~port_sel_reg[`PSEL_FCTL_LSB+1:`PSEL_FCTL_LSB];
            port_f_next[3] = ~port_sel_reg[`PSEL_FCTL_LSB+2];
            port_f_next[2:0] = {3{port_sel_reg[`PSEL_FCTL_MSB]}};
        end
        else if (expanded)
        begin
            port_f_next = {8{port_sel_reg[`PSEL_FCTL_MSB]}};
        end
    end

    assign port_f_ctrl_out = port_f_next;

    // G0 starts control in 1,2; G6-G1 and H start as I/O everywhere
    assign port_g_ctrl_out = {port_g_sel_reg[6:1],
        ((mode_now == MODE_1) || (mode_now == MODE_2)) ? ~port_g_sel_reg[0] : port_g_sel_reg[0]};
    assign port_h_ctrl_out = ~port_h_sel_reg;

    // RAM region goes external only with bus on and RAM off; modes 1, 2 and 4 always count as bus on
    assign ram_region_map_out = (expanded && !ram_en) ? REGION_EXTERNAL : REGION_RAM;
    // Expansion region reserved unless bus enabled; access there is software's fault
    assign exp_region_map_out = expanded ? REGION_EXTERNAL : REGION_RESERVED;

    // Assertions
    property ram_map_p;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (ram_region_map_out == REGION_EXTERNAL) == (expanded && !ram_en);
    endproperty
    ram_region_map_a: assert property (ram_map_p) else $error("ram region map wrong");

    exp_region_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        exp_region_map_out == (expanded ? REGION_EXTERNAL : REGION_RESERVED))
        else $error("expansion region map wrong");

    rom_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (mode_now == MODE_1 || mode_now == MODE_2) |-> !rom_enable_out && port_addr_out == 3'h7)
        else $error("rom or address in modes 1,2 wrong");

    sequence ram_write_s;
        reg_write_in && reg_addr_in == `SYSCTL_ADDR;
    endsequence
    ram_enable_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ram_write_s |=> ram_enable_out == $past(reg_wdata_in[`SYSCTL_RAM_ENABLE_BIT_BIT]))
        else $error("ram enable not written");

    read_data_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        reg_read_in && reg_addr_in == `MODEMON_ADDR |=> reg_rdata_out == {5'h00, $past(mode_select_pins_in)})
        else $error("mode monitor read wrong");

    mode_held_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        reg_read_in && reg_addr_in == `MODEMON_ADDR |=> mode_held == $past(mode_select_pins_in))
        else $error("mode latch not refreshed");

    // Any wide area in an expanded mode must widen the bus and claim port E
    width_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        expanded && reg_write_in && reg_addr_in == `AREAWID_ADDR && (|reg_wdata_in[AREAS-1:0])
        |=> bus_16bit_out && port_e_data_out)
        else $error("width without port e");

    area_narrow_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        reg_write_in && reg_addr_in == `AREAWID_ADDR && reg_wdata_in[AREAS-1:0] == '0
        |=> !bus_16bit_out && !port_e_data_out)
        else $error("bus still wide with all areas narrow");

    // Turning the bus on in modes 3 and 7 starts every area wide; a write in between may override
    sequence bus_on_s;
        single_chip_class && !ext_en && reg_write_in && reg_addr_in == `SYSCTL_ADDR
            && reg_wdata_in[`SYSCTL_EXTERNAL_BUS_ENABLE_BIT_BIT] ##1 !reg_write_in;
    endsequence
    bus_on_wide_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        bus_on_s |=> ext_bus_active_out && bus_16bit_out)
        else $error("expansion did not start wide");

    single_chip_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (mode_now == MODE_7 && !ext_en) |-> !ext_bus_active_out && port_f_ctrl_out == 8'h00)
        else $error("mode 7 not single chip");

    user_prog_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        user_program_mode_out |-> (mode_now == MODE_4 || mode_now == MODE_7) && flash_cmd_reg)
        else $error("user program mode wrong");

    port_d_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (mode_now == MODE_4) |-> port_d_data_out && rom_enable_out)
        else $error("mode 4 port d or rom wrong");

    // Second cycle after release, when no write has touched the registers yet
    sequence after_reset_s;
        $rose(area_init_done_reg) && !$past(reg_write_in);
    endsequence
    ram_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        after_reset_s |-> ram_enable_out && ram_region_map_out == REGION_RAM)
        else $error("ram not enabled after reset");

    mode1_wide_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        after_reset_s |-> !mode1_reg || (bus_16bit_out && port_e_data_out))
        else $error("mode 1 did not start wide");

    addr_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        after_reset_s |-> port_addr_out == ((mode1_reg || mode_now == MODE_2) ? 3'h7 : 3'h0))
        else $error("address ports wrong after reset");

    port_f_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        after_reset_s |-> port_f_ctrl_out ==
            ((mode_now == MODE_1 || mode_now == MODE_2 || mode_now == MODE_4) ? 8'hF8 : 8'h00))
        else $error("port f wrong after reset");

    port_h_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        after_reset_s |-> port_h_ctrl_out == 8'h00 && port_g_ctrl_out[6:1] == 6'h00)
        else $error("port g or h not io after reset");

endmodule

/* File: testbench/ext_bus_model.sv */
`timescale 1ns/1ps

// External memory on the expansion bus; LAT sets how slowly it answers
module ext_bus_model
    import opmode_pkg::*;
#(
    parameter int LAT = 2
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [1:0] region_in,
    output logic ack_out,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [16];
    int cnt;

    // Only answers where the expansion region is external; bus toggles when idle
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt <= 0;
            ack_out <= 1'b0;
            rdata_out <= 8'h00;
        end
        else
        begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if (req_in && !ack_out && region_in == REGION_EXTERNAL)
            begin
                cnt <= (cnt == LAT) ? 0 : cnt + 1;
                if (cnt == LAT)
                begin
                    ack_out <= 1'b1;
                    rdata_out <= mem[addr_in];
                    if (we_in)
                        mem[addr_in] <= wdata_in;
                end
            end
        end
    end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps

module testbench;
    import opmode_pkg::*;
    localparam logic [4:0] ROM_T = 5'h1C;
    localparam logic [4:0] EXT_T = 5'h0B;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] pins = 3'h7;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata, pf, ph, x_wdata = 8'h00, x_rdata;
    logic rom_en, ram_en, ext_on, b16, boot, upm, pd, pe, x_ack, x_req = 1'b0, x_we = 1'b0, rd_pend = 1'b0;
    logic [2:0] paddr;
    logic [6:0] pg;
    logic [1:0] ram_map, exp_map;
    logic [3:0] x_addr = 4'h0;
    logic [7:0] notes[$];
    logic [7:0] d;
    logic [7:0] v;
    const logic [2:0] mp[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int bad_count = 0;
    int tests_run = 0;

    operating_mode_pin_select dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .mode_select_pins_in(pins),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_stb), .reg_read_in(rd_stb),
        .reg_rdata_out(rdata), .rom_enable_out(rom_en), .ram_enable_out(ram_en), .ext_bus_active_out(ext_on),
        .bus_16bit_out(b16), .boot_mode_out(boot), .user_program_mode_out(upm), .port_addr_out(paddr),
        .port_d_data_out(pd), .port_e_data_out(pe), .port_f_ctrl_out(pf), .port_g_ctrl_out(pg),
        .port_h_ctrl_out(ph), .ram_region_map_out(ram_map), .exp_region_map_out(exp_map));

    ext_bus_model #(.LAT(2)) partner (.clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(x_req), .we_in(x_we),
        .addr_in(x_addr), .wdata_in(x_wdata), .region_in(exp_map), .ack_out(x_ack), .rdata_out(x_rdata));

    // Free-running system clock
    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] dat);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= dat;
        wr_stb <= 1'b1;
        @(posedge sys_clk_in);
        wr_stb <= 1'b0;
    endtask

    // Expected read data goes on the queue; the monitor below compares it
    task automatic reg_read(input logic [3:0] a, input logic [7:0] want);
        notes.push_back(want);
        @(posedge sys_clk_in);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk_in);
        rd_stb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk_in)
    begin
        if (rd_pend)
            check("read data", rdata, notes.pop_front());
        rd_pend <= rd_stb;
    end

    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask

    // Mode pins only change while reset is held
    task automatic do_reset(input logic [2:0] p);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        pins <= p;
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        settle();
    endtask

    // Expansion bus access, held until the partner acknowledges or 10 cycles pass
    task automatic ext_access(input logic we, input logic [3:0] a, input logic [7:0] dat);
        logic got;
        got = 1'b0;
        @(posedge sys_clk_in);
        x_req <= 1'b1;
        x_we <= we;
        x_addr <= a;
        x_wdata <= dat;
        for (int n = 0; n < 10 && !got; n++)
        begin
            @(posedge sys_clk_in);
            got = (x_ack === 1'b1);
        end
        check("ext ack", {7'h00, got}, 8'h01);
        if (!we && got)
            check("ext data", x_rdata, dat);
        x_req <= 1'b0;
    endtask

    initial
    begin
        #400000;
        bad_count++;
        $display("Watchdog expired");
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h05FA));
        for (int i = 0; i < 5; i++)
        begin
            do_reset(mp[i]);
            check("rom enable", {7'h00, rom_en}, {7'h00, ROM_T[i]});
            check("ext active", {7'h00, ext_on}, {7'h00, EXT_T[i]});
            check("bus 16", {7'h00, b16}, {7'h00, i == 0});
            check("port e", {7'h00, pe}, {7'h00, i == 0});
            check("boot", {7'h00, boot}, {7'h00, i == 2});
            check("port addr", {5'h00, paddr}, (i < 2) ? 8'h07 : 8'h00);
            check("port d", {7'h00, pd}, {7'h00, EXT_T[i]});
            check("port f", pf, EXT_T[i] ? 8'hF8 : 8'h00);
            check("port g", {1'b0, pg}, {7'h00, i < 2});
            check("port h", ph, 8'h00);
            check("ram enable", {7'h00, ram_en}, 8'h01);
            check("ram map", {6'h00, ram_map}, {6'h00, REGION_RAM});
            check("exp map", {6'h00, exp_map}, EXT_T[i] ? 8'h01 : 8'h02);
            reg_read(4'h0, 8'hC1);
            reg_read(4'h1, {5'h00, mp[i]});
            reg_write(4'h3, 8'h01);
            settle();
            check("user program", {7'h00, upm}, {7'h00, i > 2});
            if (i == 0)
            begin
                reg_write(4'h2, 8'h00);
                settle();
                check("bus 16 all narrow", {7'h00, b16}, 8'h00);
            end
            if (i == 1 || i == 3)
            begin
                for (int k = 0; k < 5; k++)
                begin
                    d = (k == 4) ? 8'h00 : 8'($urandom_range(255, 1));
                    reg_write(4'h2, d);
                    settle();
                    check("bus 16 any wide", {7'h00, b16}, {7'h00, |d});
                    check("port e wide", {7'h00, pe}, {7'h00, |d});
                end
                if (i == 3)
                begin
                    reg_write(4'h4, 8'h57);
                    reg_write(4'h5, 8'hA5);
                    settle();
                    check("port addr sel", {5'h00, paddr}, 8'h07);
                    check("port f sel", pf, 8'hB0);
                    check("port g sel", {1'b0, pg}, 8'h25);
                    check("port h sel", ph, 8'hA5);
                    reg_read(4'h4, 8'h57);
                    reg_read(4'h5, 8'h25);
                end
            end
            if (i == 2 || i == 4)
            begin
                v = (i == 2) ? 8'h01 : 8'h00;
                reg_write(4'h0, 8'hC0 | v);
                settle();
                check("ram enable off", {7'h00, ram_en}, v);
                check("ram map single", {6'h00, ram_map}, {6'h00, REGION_RAM});
                reg_write(4'h0, 8'hC2 | v);
                settle();
                check("expanded", {7'h00, ext_on}, 8'h01);
                check("expanded 16", {7'h00, b16}, 8'h01);
                check("ram map exp", {6'h00, ram_map}, v[0] ? 8'h00 : 8'h01);
                check("exp map on", {6'h00, exp_map}, 8'h01);
                if (exp_map == REGION_EXTERNAL)
                begin
                    ext_access(1'b1, 4'h3, 8'h5A);
                    ext_access(1'b0, 4'h3, 8'h5A);
                end
                reg_write(4'h0, 8'hC7);
                reg_write(4'hF, 8'hFF);
                reg_read(4'h0, 8'hC3);
                reg_read(4'hF, 8'h00);
                settle();
                check("ram map back", {6'h00, ram_map}, {6'h00, REGION_RAM});
            end
            $display("Mode %0d done", mp[i]);
        end
        settle();
        complete_run();
    end
endmodule
